/* File: rtl/page_modify_pkg.sv */
package page_modify_pkg;
  // leaf selector codes
  localparam logic [7:0] LEAF_RESTRICT = 8'h0E;
  localparam logic [7:0] LEAF_CHANGE_TYPE = 8'h0F;
  // alignment widths in low address bits
  localparam int INFO_ALIGN_BITS = 6;
  localparam int PAGE_ALIGN_BITS = 12;
  // page type encodings
  localparam logic [7:0] PT_ENCLAVE_CONTROL_STRUCT_CODE = 8'h00;
  localparam logic [7:0] PT_TCS_CODE = 8'h01;
  localparam logic [7:0] REGULAR_PAGE_TYPE_CODE = 8'h02;
  localparam logic [7:0] PT_VA_CODE = 8'h03;
  localparam logic [7:0] PT_TRIM_CODE = 8'h04;
  localparam logic [7:0] PT_SS_FIRST_CODE = 8'h05;
  localparam logic [7:0] PT_SS_REST_CODE = 8'h06;
  // error codes in the result register
  localparam logic [31:0] ERR_NONE = 32'h0000_0000;
  localparam logic [31:0] ERR_NOT_CHANGEABLE = 32'h0000_000A;
  localparam logic [31:0] ERR_PAGE_BUSY = 32'h0000_0007;
  // page attribute entry field layout (packed word)
  localparam int ATTR_R = 0;
  localparam int ATTR_W = 1;
  localparam int ATTR_X = 2;
  localparam int ATTR_PENDING = 3;
  localparam int ATTR_MODIFIED = 4;
  localparam int ATTR_PR = 5;
  localparam int ATTR_VALID = 6;
  localparam int ATTR_PT_LSB = 8;
  localparam int ATTR_WIDTH = 16;
  localparam logic [15:0] ATTR_RESET = 16'h0000;
  // fault kinds
  typedef enum logic [1:0] {FAULT_NONE, FAULT_GENERAL, FAULT_PAGE} fault_type;
endpackage

/* File: rtl/align_check.sv */
`timescale 1ns/1ps
`default_nettype none
// flags an address whose low bits are not all zero
module align_check #(
  parameter int ADDR_W = 64,
  parameter int LOW_BITS = 6
) (
  // address under test
  input wire logic [ADDR_W-1:0] addr,
  // high when misaligned
  output logic misaligned
);
  assign misaligned = |addr[LOW_BITS-1:0];
endmodule // align_check
`default_nettype wire

/* File: rtl/attr_update.sv */
`timescale 1ns/1ps
`default_nettype none
// computes the new attribute entry for either leaf
module attr_update
  import page_modify_pkg::*;
(
  // operation select, high for type change
  input wire logic change_type,
  // current entry
  input wire logic [ATTR_WIDTH-1:0] entry,
  // mask bits and requested type from the info struct
  input wire logic [2:0] rwx_mask,
  input wire logic [7:0] new_type,
  // updated entry
  output logic [ATTR_WIDTH-1:0] next_entry
);
  always_comb begin
    next_entry = entry;
    if (change_type) begin
      // new type is locked out until accepted: modified set, rights cleared
      next_entry[ATTR_PR] = 1'b0;
      next_entry[ATTR_MODIFIED] = 1'b1;
      next_entry[ATTR_R] = 1'b0;
      next_entry[ATTR_W] = 1'b0;
      next_entry[ATTR_X] = 1'b0;
      next_entry[ATTR_PT_LSB +: 8] = new_type;
    end else begin
      next_entry[ATTR_PR] = 1'b1;
      // mask only ever removes rights
      next_entry[ATTR_R] = entry[ATTR_R] & rwx_mask[0];
      next_entry[ATTR_W] = entry[ATTR_W] & rwx_mask[1];
      next_entry[ATTR_X] = entry[ATTR_X] & rwx_mask[2];
    end
  end
endmodule // attr_update
`default_nettype wire

/* File: rtl/page_modify_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module page_modify_checker
  import page_modify_pkg::*;
#(
  parameter int ADDR_W = 64
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // request
  input wire logic req_valid,
  input wire logic [7:0] leaf_selector_reg,
  input wire logic [1:0] cpl,
  input wire logic [ADDR_W-1:0] info_addr,
  input wire logic [ADDR_W-1:0] page_addr,
  output logic busy,
  // page info struct contents and environment
  input wire logic page_in_cache,
  input wire logic info_rsvd_nonzero,
  input wire logic [2:0] info_rwx,
  input wire logic [7:0] info_type,
  input wire logic first_gen_active,
  input wire logic second_gen_active,
  input wire logic enclave_initialized,
  // attribute entry port
  input wire logic [ATTR_WIDTH-1:0] entry_rdata,
  output logic entry_we,
  output logic [ATTR_WIDTH-1:0] entry_wdata,
  // completion
  output logic done,
  output var fault_type fault,
  output logic result_flag,
  output logic [31:0] result_reg,
  output logic [4:0] arith_flags
);
  typedef enum logic [1:0] {IDLE, CHECK, FINISH} state_type;
  state_type state;
  // latched request
  logic op_type;
  logic [ADDR_W-1:0] info_q;
  logic [ADDR_W-1:0] page_q;
  logic [1:0] cpl_q;
  // decision of the check stage
  fault_type next_fault;
  logic next_flag;
  logic [31:0] next_code;
  logic next_we;
  logic info_mis;
  logic page_mis;
  logic [ATTR_WIDTH-1:0] upd;
  logic [7:0] cur_pt;
  logic trim_ok;

  // low-bit alignment checks for both operands
  align_check #(.ADDR_W(ADDR_W), .LOW_BITS(INFO_ALIGN_BITS)) u_info_align (
    .addr(info_q),
    .misaligned(info_mis)
  );
  align_check #(.ADDR_W(ADDR_W), .LOW_BITS(PAGE_ALIGN_BITS)) u_page_align (
    .addr(page_q),
    .misaligned(page_mis)
  );
  // next entry value for whichever leaf was taken
  attr_update u_update (
    .change_type(op_type),
    .entry(entry_rdata),
    .rwx_mask(info_rwx),
    .new_type(info_type),
    .next_entry(upd)
  );

  assign cur_pt = entry_rdata[ATTR_PT_LSB +: 8];
  // trim is allowed from tcs and shadow-stack pages
  assign trim_ok = (info_type == PT_TRIM_CODE) && (cur_pt == PT_TCS_CODE ||
    cur_pt == PT_SS_FIRST_CODE || cur_pt == PT_SS_REST_CODE);

  // check sequence in documented priority order
  always_comb begin
    next_fault = FAULT_NONE;
    next_flag = 1'b0;
    next_code = ERR_NONE;
    next_we = 1'b0;
    if (op_type && cpl_q != 2'd0) begin
      next_fault = FAULT_GENERAL;
    end else if (info_mis) begin
      next_fault = FAULT_GENERAL;
    end else if (page_mis) begin
      next_fault = FAULT_GENERAL;
    end else if (!page_in_cache) begin
      next_fault = FAULT_PAGE;
    end else if (info_rsvd_nonzero ||
        (!op_type && !info_rwx[0] && info_rwx[1])) begin
      next_fault = FAULT_GENERAL;
    end else if (op_type && !(info_type == PT_TCS_CODE || info_type == PT_TRIM_CODE)) begin
      next_fault = FAULT_GENERAL;
    end else if (!op_type && first_gen_active) begin
      // second-generation clashes are left to the busy code further down
      next_fault = FAULT_GENERAL;
    end else if (op_type && first_gen_active) begin
      next_flag = 1'b1;
      next_code = ERR_PAGE_BUSY;
    end else if (!entry_rdata[ATTR_VALID]) begin
      next_fault = FAULT_PAGE;
    end else if (second_gen_active) begin
      // busy: flag and code, no entry write
      next_flag = 1'b1;
      next_code = ERR_PAGE_BUSY;
    end else if (op_type && !(cur_pt == REGULAR_PAGE_TYPE_CODE || trim_ok)) begin
      next_fault = FAULT_PAGE;
    end else if (entry_rdata[ATTR_PENDING] || entry_rdata[ATTR_MODIFIED]) begin
      next_flag = 1'b1;
      next_code = ERR_NOT_CHANGEABLE;
    end else if (!op_type && cur_pt != REGULAR_PAGE_TYPE_CODE) begin
      next_fault = FAULT_PAGE;
    end else if (!enclave_initialized) begin
      next_fault = FAULT_GENERAL;
    end else begin
      next_we = 1'b1;
    end
  end

  // sequencer: latch, check, pulse done
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= IDLE;
    end else begin
      case (state)
        IDLE: if (req_valid) state <= CHECK;
        CHECK: state <= FINISH;
        FINISH: state <= IDLE;
        default: state <= IDLE;
      endcase
    end
  end

  // request capture, only while idle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      op_type <= 1'b0;
      info_q <= '0;
      page_q <= '0;
      cpl_q <= 2'd0;
    end else if (state == IDLE && req_valid) begin
      // any leaf other than 0FH is treated as restrict
      op_type <= (leaf_selector_reg == LEAF_CHANGE_TYPE);
      info_q <= info_addr;
      page_q <= page_addr;
      cpl_q <= cpl;
    end
  end

  // busy indication, registered
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= (state == IDLE) ? req_valid : (state == CHECK);
    end
  end

  // entry write and completion outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      entry_we <= 1'b0;
      entry_wdata <= ATTR_RESET;
      done <= 1'b0;
      fault <= FAULT_NONE;
      result_flag <= 1'b0;
      result_reg <= ERR_NONE;
      arith_flags <= 5'h0_0;
    end else begin
      entry_we <= (state == CHECK) && next_we;
      done <= (state == CHECK);
      if (state == CHECK) begin
        entry_wdata <= upd;
        fault <= next_fault;
        result_flag <= next_flag;
        result_reg <= next_code;
        arith_flags <= 5'h0_0;
      end
    end
  end

  // completion and sequencing checks

  // a request that the idle sequencer accepts
  sequence seq_take;
    state == IDLE && req_valid;
  endsequence
  // the single check cycle after a take
  sequence seq_check;
    state == CHECK && busy;
  endsequence
  // the completion cycle with its pulse
  sequence seq_finish;
    done && busy;
  endsequence

  // done is a single-cycle pulse
  chk_done_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    done |=> !done)
    else $error("done longer than one cycle");
  // a write never goes out with an error
  chk_busy_no_write: assert property (@(posedge clock) disable iff (!rst_n)
    entry_we |-> !result_flag && fault == FAULT_NONE)
    else $error("write on error");
  // the entry write rides on the done pulse
  chk_write_with_done: assert property (@(posedge clock) disable iff (!rst_n)
    entry_we |-> done)
    else $error("write without done");
  // success returns code zero
  chk_success_code: assert property (@(posedge clock) disable iff (!rst_n)
    entry_we |-> result_reg == ERR_NONE)
    else $error("nonzero code on success");
  // restrict marks the entry as in progress
  chk_restrict_pr: assert property (@(posedge clock) disable iff (!rst_n)
    entry_we && !op_type |-> entry_wdata[ATTR_PR])
    else $error("restrict mark not set");
  // type change locks the page until accepted
  chk_type_modified: assert property (@(posedge clock) disable iff (!rst_n)
    entry_we && op_type |-> entry_wdata[ATTR_MODIFIED])
    else $error("not blocked");
  // arithmetic flags are cleared on every completion
  chk_arith_clear: assert property (@(posedge clock) disable iff (!rst_n)
    done |-> arith_flags == 5'h0_0)
    else $error("flags not cleared");
  // fixed two-edge answer time
  chk_done_latency: assert property (@(posedge clock) disable iff (!rst_n)
    seq_take |-> ##2 done)
    else $error("done late");
  // take, check and finish follow in lock step
  chk_take_order: assert property (@(posedge clock) disable iff (!rst_n)
    seq_take |=> seq_check ##1 seq_finish)
    else $error("sequencer out of step");
  // a busy sequencer ignores requests, so the latched operands hold
  chk_busy_refuse: assert property (@(posedge clock) disable iff (!rst_n)
    state != IDLE |=> $stable(op_type) && $stable(page_q) && $stable(info_q))
    else $error("request taken while busy");
  // busy rises on the take
  chk_busy_rise: assert property (@(posedge clock) disable iff (!rst_n)
    seq_take |=> busy)
    else $error("busy missing after take");
  // busy stays up until the done pulse
  chk_busy_hold: assert property (@(posedge clock) disable iff (!rst_n)
    busy && !done |=> busy)
    else $error("busy dropped early");
  // busy falls right after done
  chk_busy_fall: assert property (@(posedge clock) disable iff (!rst_n)
    done |=> !busy)
    else $error("busy stuck after done");
  // the check stage lasts one cycle
  chk_check_once: assert property (@(posedge clock) disable iff (!rst_n)
    seq_check |=> state == FINISH)
    else $error("check stage too long");
  // the entry write is a single pulse
  chk_we_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    entry_we |=> !entry_we)
    else $error("write longer than one cycle");
  // results hold between completions
  chk_result_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !done |-> $stable(result_reg) && $stable(result_flag) && $stable(fault))
    else $error("result changed without done");
  // a fault carries neither flag nor write
  chk_fault_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    done && fault != FAULT_NONE |-> !result_flag && !entry_we)
    else $error("fault with flag or write");
  // a set flag always carries a nonzero code
  chk_flag_code: assert property (@(posedge clock) disable iff (!rst_n)
    done && result_flag |-> result_reg != ERR_NONE)
    else $error("flag without code");
  // privilege above zero stops a type change
  chk_priv_fault: assert property (@(posedge clock) disable iff (!rst_n)
    seq_take ##0 (leaf_selector_reg == LEAF_CHANGE_TYPE && cpl != 2'd0) |-> ##2 (done && fault == FAULT_GENERAL))
    else $error("type change at high privilege");
  // misaligned info struct is a general fault
  chk_info_align: assert property (@(posedge clock) disable iff (!rst_n)
    seq_take ##0 (|info_addr[INFO_ALIGN_BITS-1:0]) |-> ##2 (fault == FAULT_GENERAL))
    else $error("info misalignment missed");
  // misaligned page is a general fault
  chk_page_align: assert property (@(posedge clock) disable iff (!rst_n)
    seq_take ##0 (|page_addr[PAGE_ALIGN_BITS-1:0]) |-> ##2 (fault == FAULT_GENERAL))
    else $error("page misalignment missed");
  // restrict only ever removes rights
  chk_mask_and: assert property (@(posedge clock) disable iff (!rst_n)
    entry_we && !op_type |->
      entry_wdata[ATTR_X:ATTR_R] == ($past(entry_rdata[ATTR_X:ATTR_R]) & $past(info_rwx)))
    else $error("rights not masked");
  // type change clears rights and the restrict mark
  chk_type_locked: assert property (@(posedge clock) disable iff (!rst_n)
    entry_we && op_type |-> entry_wdata[ATTR_X:ATTR_R] == 3'h0 && !entry_wdata[ATTR_PR])
    else $error("rights left after type change");
endmodule // page_modify_checker
`default_nettype wire

/* File: bench/leaf_issuer.sv */
`timescale 1ns/1ps
`default_nettype none
// software side: loads leaf code, operands and the page environment
module leaf_issuer
  import page_modify_pkg::*;
(
  // request
  output logic req_valid,
  output logic [7:0] leaf_selector_reg,
  output logic [1:0] cpl,
  output logic [63:0] info_addr,
  output logic [63:0] page_addr,
  // environment {cache, rsvd, first, second, init}
  output logic [4:0] env,
  output logic [2:0] info_rwx,
  output logic [7:0] info_type,
  output logic [15:0] entry_rdata
);
  // idle at time zero
  initial begin
    {req_valid, leaf_selector_reg, cpl, info_addr, page_addr, env, info_rwx} = '0;
    {info_type, entry_rdata} = '0;
  end
  // operands stay put after the request drops, so the check cycle sees them
  task automatic issue(input logic chg, input logic [1:0] c, input logic [63:0] ia, pa,
      input logic [4:0] e, input logic [2:0] m, input logic [7:0] t, input logic [15:0] ent);
    leaf_selector_reg = chg ? LEAF_CHANGE_TYPE : LEAF_RESTRICT;
    {cpl, info_addr, page_addr, env, info_rwx, info_type, entry_rdata} = {c, ia, pa, e, m, t, ent};
    req_valid = 1'b1;
  endtask
  // release the request once taken
  task automatic drop();
    req_valid = 1'b0;
  endtask
endmodule // leaf_issuer
`default_nettype wire

/* File: bench/enclave_page_modify_checker_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module enclave_page_modify_checker_tb;
  import page_modify_pkg::*;
  // operands known to pass every check
  localparam logic [63:0] IA = 64'h0000_0000_0000_1040;
  localparam logic [63:0] PA = 64'h0000_0000_0000_2000;
  localparam logic [15:0] ENT = 16'h0247;
  logic clock, rst_n, req_valid, busy, entry_we, done, result_flag;
  logic [7:0] leaf_selector_reg, info_type;
  logic [1:0] cpl;
  logic [63:0] info_addr, page_addr;
  logic [4:0] env, arith_flags;
  logic [2:0] info_rwx;
  logic [15:0] entry_rdata, entry_wdata;
  logic [31:0] result_reg;
  fault_type fault;
  int num_errors = 0;
  int cmp_count = 0;
  page_modify_checker page_modify_checker_i (.clock(clock), .rst_n(rst_n),
    .req_valid(req_valid), .leaf_selector_reg(leaf_selector_reg), .cpl(cpl),
    .info_addr(info_addr), .page_addr(page_addr), .busy(busy), .page_in_cache(env[4]),
    .info_rsvd_nonzero(env[3]), .info_rwx(info_rwx), .info_type(info_type),
    .first_gen_active(env[2]), .second_gen_active(env[1]), .enclave_initialized(env[0]),
    .entry_rdata(entry_rdata), .entry_we(entry_we), .entry_wdata(entry_wdata), .done(done),
    .fault(fault), .result_flag(result_flag), .result_reg(result_reg),
    .arith_flags(arith_flags));
  leaf_issuer leaf_issuer_i (.req_valid(req_valid), .leaf_selector_reg(leaf_selector_reg),
    .cpl(cpl), .info_addr(info_addr), .page_addr(page_addr), .env(env),
    .info_rwx(info_rwx), .info_type(info_type), .entry_rdata(entry_rdata));
  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask
  // one leaf: taken at the next edge, done exactly one edge later
  task automatic go(input logic chg, input logic [1:0] c, input logic [63:0] ia, pa,
      input logic [4:0] e, input logic [2:0] m, input logic [7:0] t, input logic [15:0] ent);
    @(negedge clock);
    leaf_issuer_i.issue(chg, c, ia, pa, e, m, t, ent);
    @(negedge clock);
    leaf_issuer_i.drop();
    chk(busy, 1);
    chk(done, 0);
    @(negedge clock);
    chk(done, 1);
  endtask
  // judge the completion; flag and code only mean something without a fault
  task automatic res(input fault_type f, input logic fl, input logic [31:0] code,
      input logic [15:0] wd);
    chk(fault, f);
    chk(entry_we, (f == FAULT_NONE && !fl));
    if (f == FAULT_NONE) begin
      chk(result_flag, fl);
      chk(result_reg, code);
      chk(arith_flags, 0);
      if (!fl) chk(entry_wdata, wd);
    end
    @(negedge clock);
    chk(done, 0);
  endtask
  // operand and environment faults, one at a time
  task automatic s_faults();
    go(0, 0, IA | 64'h0000_0000_0000_0020, PA, 5'h11, 3'h7, 0, ENT); res(FAULT_GENERAL, 0, 0, 0);
    go(0, 0, IA, PA | 64'h0000_0000_0000_0800, 5'h11, 3'h7, 0, ENT); res(FAULT_GENERAL, 0, 0, 0);
    go(0, 0, IA, PA, 5'h01, 3'h7, 0, ENT); res(FAULT_PAGE, 0, 0, 0);
    go(0, 0, IA, PA, 5'h19, 3'h7, 0, ENT); res(FAULT_GENERAL, 0, 0, 0);
    go(0, 0, IA, PA, 5'h11, 3'h2, 0, ENT); res(FAULT_GENERAL, 0, 0, 0);
    go(0, 0, IA, PA, 5'h15, 3'h7, 0, ENT); res(FAULT_GENERAL, 0, 0, 0);
    go(0, 0, IA, PA, 5'h11, 3'h7, 0, 16'h0207); res(FAULT_PAGE, 0, 0, 0);
    go(0, 0, IA, PA, 5'h11, 3'h7, 0, 16'h0147); res(FAULT_PAGE, 0, 0, 0);
    go(0, 0, IA, PA, 5'h10, 3'h7, 0, ENT); res(FAULT_GENERAL, 0, 0, 0);
    go(1, 3, IA, PA, 5'h11, 3'h0, PT_TRIM_CODE, ENT); res(FAULT_GENERAL, 0, 0, 0);
  endtask
  // error-code completions leave the entry alone
  task automatic s_codes();
    go(0, 0, IA, PA, 5'h13, 3'h7, 0, ENT); res(FAULT_NONE, 1, ERR_PAGE_BUSY, 0);
    go(1, 0, IA, PA, 5'h13, 3'h0, PT_TRIM_CODE, ENT); res(FAULT_NONE, 1, ERR_PAGE_BUSY, 0);
    go(0, 0, IA, PA, 5'h11, 3'h7, 0, 16'h024F); res(FAULT_NONE, 1, ERR_NOT_CHANGEABLE, 0);
    go(1, 0, IA, PA, 5'h11, 3'h0, PT_TCS_CODE, 16'h0257); res(FAULT_NONE, 1, ERR_NOT_CHANGEABLE, 0);
  endtask
  // successful updates of the attribute entry
  task automatic s_success();
    go(0, 0, IA, PA, 5'h11, 3'h1, 0, ENT); res(FAULT_NONE, 0, ERR_NONE, 16'h0261);
    go(0, 0, IA, PA, 5'h11, 3'h7, 0, 16'h0243); res(FAULT_NONE, 0, ERR_NONE, 16'h0263);
    go(1, 0, IA, PA, 5'h11, 3'h7, PT_TRIM_CODE, ENT); res(FAULT_NONE, 0, ERR_NONE, 16'h0450);
    go(1, 0, IA, PA, 5'h11, 3'h0, PT_TCS_CODE, ENT); res(FAULT_NONE, 0, ERR_NONE, 16'h0150);
  endtask
  // counts, verdict, end of run
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // main sequence after a 20-cycle reset
  initial begin
    rst_n = 1'b0;
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    s_faults();
    s_codes();
    s_success();
    give_verdict();
  end
  // hang guard, well past the ~90 cycles the run needs
  initial begin
    #20000;
    num_errors++;
    give_verdict();
  end
endmodule // enclave_page_modify_checker_tb
`default_nettype wire
